//--- rtl/timer_counter_defines.svh
// Constants for the timer/counter unit: reset values and timing counts.
`ifndef TIMER_COUNTER_DEFINES_SVH
`define TIMER_COUNTER_DEFINES_SVH

// ----------------------------------------------------------------------------
// Timing and counter width
// ----------------------------------------------------------------------------
`define OSC_PER_MACHINE_CYCLE 6
`define TIMER_WIDTH           16

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define TIMER_RESET_VALUE     16'h0000
`define T2_MODE_RESET         2'h0
`define T2_RELOAD_RESET       2'h0
`define T2_PRESCALE_RESET     1'h0
`define PIN_IDLE_LEVEL        1'h1

`endif

//--- rtl/timer_counter_pkg.sv
// Types shared by the timer/counter unit.
package timer_counter_pkg;

   // -------------------------------------------------------------------------
   // Timer 2 operating mode and reload mode
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      T2_STOPPED = 2'h0,
      T2_TIMER   = 2'h1,
      T2_EVENT   = 2'h2,
      T2_GATED   = 2'h3
   } t2_mode_t;

   typedef enum logic [1:0] {
      RELOAD_OFF      = 2'h0,
      RELOAD_OVERFLOW = 2'h1,
      RELOAD_EXTERNAL = 2'h2,
      RELOAD_SPARE    = 2'h3
   } reload_mode_t;

   // -------------------------------------------------------------------------
   // Machine cycle phase tracker
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      PHASE_FIRST  = 2'b01,
      PHASE_SECOND = 2'b10
   } t2_phase_t;

endpackage

//--- rtl/pin_sampler.sv
// Synchroniser and machine-cycle sampler with falling-edge detection for one pin.
`timescale 1ns/100ps
`include "timer_counter_defines.svh"

module pin_sampler
   import timer_counter_pkg::*;
(
   input  wire logic mclk_i,
   input  wire logic reset_i,
   input  wire logic pin_i,
   input  wire logic sample_i,
   output logic      level_o,
   output logic      fall_o
);

   logic sync1_q;
   logic sync2_q;
   logic smp_q;
   logic fall_q;
   logic fall_d;

   // A fall is a high sample followed by a low sample, so it spans two
   // machine cycles and a level must stand for at least one of them.
   assign fall_d = sample_i & smp_q & ~sync2_q;

   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         sync1_q <= `PIN_IDLE_LEVEL;
         sync2_q <= `PIN_IDLE_LEVEL;
         smp_q   <= `PIN_IDLE_LEVEL;
         fall_q  <= 1'b0;
      end
      else
      begin
         sync1_q <= pin_i;
         sync2_q <= sync1_q;
         if (sample_i)
         begin
            smp_q <= sync2_q;
         end
         fall_q <= fall_d;
      end
   end

   assign level_o = smp_q;
   assign fall_o  = fall_q;

endmodule

//--- rtl/timer_counter_unit.sv
// Timer/counter unit: timers 0 and 1 plus the reloadable 16-bit timer 2.
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`timescale 1ns/100ps
`include "timer_counter_defines.svh"

module timer_counter_unit
   import timer_counter_pkg::*;
#(
   parameter int          WIDTH         = `TIMER_WIDTH,
   parameter int unsigned OSC_PER_CYCLE = `OSC_PER_MACHINE_CYCLE
)
(
   input  wire logic             mclk_i,
   input  wire logic             reset_i,
   input  wire logic             timer0_count_pin_i,
   input  wire logic             timer1_count_pin_i,
   input  wire logic             ext_irq0_gate_pin_n_i,
   input  wire logic             ext_irq1_gate_pin_n_i,
   input  wire logic             timer2_gate_count_pin_i,
   input  wire logic             timer2_reload_trigger_pin_i,
   input  wire logic             t0_run_i,
   input  wire logic             t0_counter_sel_i,
   input  wire logic             t0_gate_en_i,
   input  wire logic             t1_run_i,
   input  wire logic             t1_counter_sel_i,
   input  wire logic             t1_gate_en_i,
   input  wire logic             t01_write_i,
   input  wire logic             t01_write_sel_i,
   input  wire logic [WIDTH-1:0] t01_write_data_i,
   input  wire logic [1:0]       t2_mode_i,
   input  wire logic             t2_prescale_div12_i,
   input  wire logic [1:0]       t2_reload_mode_i,
   input  wire logic             t2_external_trigger_enable_i,
   input  wire logic             control_write_i,
   input  wire logic [WIDTH-1:0] t2_reload_value_i,
   input  wire logic             t2_write_i,
   input  wire logic [WIDTH-1:0] t2_write_data_i,
   input  wire logic             t2_overflow_clear_i,
   input  wire logic             t2_external_clear_i,
   output logic [WIDTH-1:0]      t0_count_o,
   output logic [WIDTH-1:0]      t1_count_o,
   output logic                  t0_overflow_o,
   output logic                  t1_overflow_o,
   output logic [WIDTH-1:0]      timer2_count_o,
   output logic [1:0]            t2_mode_o,
   output logic                  t2_overflow_flag_o,
   output logic                  t2_external_flag_o
);

   // -------------------------------------------------------------------------
   // Arithmetic
   // -------------------------------------------------------------------------
   function automatic logic [WIDTH:0] increment(input logic [WIDTH-1:0] value);
      increment = {1'b0, value} + {{WIDTH{1'b0}}, 1'b1};
   endfunction

   // -------------------------------------------------------------------------
   // Machine cycle generation
   // -------------------------------------------------------------------------
   logic [3:0]   osc_cnt_q;
   logic [3:0]   osc_cnt_d;
   logic         cycle_tick;
   t2_phase_t    phase_q;
   t2_phase_t    phase_d;

   assign cycle_tick = (osc_cnt_q == 4'(OSC_PER_CYCLE - 1));
   assign osc_cnt_d  = cycle_tick ? 4'h0 : osc_cnt_q + 4'h1;

   // The phase bit halves the tick rate for the divide-by-twelve prescaler.
   always_comb
   begin
      case (phase_q)
         PHASE_FIRST:  phase_d = cycle_tick ? PHASE_SECOND : PHASE_FIRST;
         PHASE_SECOND: phase_d = cycle_tick ? PHASE_FIRST : PHASE_SECOND;
         default:      phase_d = PHASE_FIRST;
      endcase
   end

   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         osc_cnt_q <= 4'h0;
         phase_q   <= PHASE_FIRST;
      end
      else
      begin
         osc_cnt_q <= osc_cnt_d;
         phase_q   <= phase_d;
      end
   end

   // -------------------------------------------------------------------------
   // Pin sampling
   // -------------------------------------------------------------------------
   // The samplers flag an edge one clock after the sampling tick, so the
   // count logic sees it on a delayed tick; this costs one clock of latency.
   logic [5:0] pin_raw;
   logic [5:0] pin_level;
   logic [5:0] pin_fall;

   assign pin_raw = {timer2_reload_trigger_pin_i, timer2_gate_count_pin_i,
                     ext_irq1_gate_pin_n_i, ext_irq0_gate_pin_n_i,
                     timer1_count_pin_i, timer0_count_pin_i};

   for (genvar i = 0; i < 6; i++)
   begin : g_pin
      pin_sampler u_pin (
         .mclk_i   (mclk_i),
         .reset_i  (reset_i),
         .pin_i    (pin_raw[i]),
         .sample_i (cycle_tick),
         .level_o  (pin_level[i]),
         .fall_o   (pin_fall[i])
      );
   end

   // -------------------------------------------------------------------------
   // Timers 0 and 1
   // -------------------------------------------------------------------------
   logic [1:0]       t01_run;
   logic [1:0]       t01_counter_sel;
   logic [1:0]       t01_gate_en;
   logic [1:0]       t01_inc;
   logic [1:0]       t01_ovf;
   logic [WIDTH-1:0] t01_cnt [2];

   assign t01_run         = {t1_run_i, t0_run_i};
   assign t01_counter_sel = {t1_counter_sel_i, t0_counter_sel_i};
   assign t01_gate_en     = {t1_gate_en_i, t0_gate_en_i};

   for (genvar t = 0; t < 2; t++)
   begin : g_t01
      logic             gate_open;
      logic             count_src;
      logic             load;
      logic [WIDTH:0]   next_val;
      logic [WIDTH-1:0] cnt_q;
      logic             ovf_q;

      // The gate pins act high here: a high sample opens the gate.
      assign gate_open  = ~t01_gate_en[t] | pin_level[2 + t];
      assign count_src  = t01_counter_sel[t] ? pin_fall[t] : cycle_tick;
      assign load       = t01_write_i & (t01_write_sel_i == 1'(t));
      assign t01_inc[t] = t01_run[t] & gate_open & count_src;
      assign next_val   = increment(cnt_q);

      always_ff @(posedge mclk_i or posedge reset_i)
      begin
         if (reset_i)
         begin
            cnt_q <= `TIMER_RESET_VALUE;
            ovf_q <= 1'b0;
         end
         else
         begin
            ovf_q <= 1'b0;
            if (load)
            begin
               cnt_q <= t01_write_data_i;
            end
            else if (t01_inc[t])
            begin
               cnt_q <= next_val[WIDTH-1:0];
               ovf_q <= next_val[WIDTH];
            end
         end
      end

      assign t01_cnt[t] = cnt_q;
      assign t01_ovf[t] = ovf_q;
   end

   assign t0_count_o    = t01_cnt[0];
   assign t1_count_o    = t01_cnt[1];
   assign t0_overflow_o = t01_ovf[0];
   assign t1_overflow_o = t01_ovf[1];

   // -------------------------------------------------------------------------
   // Timer 2 control
   // -------------------------------------------------------------------------
   t2_mode_t     mode_q;
   reload_mode_t reload_q;
   logic         div12_q;
   logic         ext_en_q;

   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         mode_q   <= t2_mode_t'(`T2_MODE_RESET);
         reload_q <= reload_mode_t'(`T2_RELOAD_RESET);
         div12_q  <= `T2_PRESCALE_RESET;
         ext_en_q <= 1'b0;
      end
      else if (control_write_i)
      begin
         mode_q   <= t2_mode_t'(t2_mode_i);
         reload_q <= reload_mode_t'(t2_reload_mode_i);
         div12_q  <= t2_prescale_div12_i;
         ext_en_q <= t2_external_trigger_enable_i;
      end
   end

   // -------------------------------------------------------------------------
   // Timer 2 counting and reload
   // -------------------------------------------------------------------------
   logic [WIDTH-1:0] t2_q;
   logic [WIDTH-1:0] t2_d;
   logic [WIDTH:0]   t2_next;
   logic             prescale_tick;
   logic             gate_high;
   logic             t2_inc;
   logic             t2_rollover;
   logic             trig_fall;
   logic             ext_reload;
   logic             ovf_reload;
   logic             ovf_flag_q;
   logic             ext_flag_q;

   assign prescale_tick = cycle_tick & (~div12_q | (phase_q == PHASE_SECOND));
   assign gate_high     = pin_level[4];

   always_comb
   begin
      case (mode_q)
         T2_TIMER: t2_inc = prescale_tick;
         T2_GATED: t2_inc = prescale_tick & gate_high;
         T2_EVENT: t2_inc = pin_fall[4];
         default:  t2_inc = 1'b0;
      endcase
   end

   assign t2_next     = increment(t2_q);
   assign t2_rollover = t2_inc & t2_next[WIDTH];
   assign trig_fall   = pin_fall[5];
   // Mode 2 reloads on any trigger fall; the enable bit only decides the flag.
   assign ext_reload  = trig_fall & (reload_q == RELOAD_EXTERNAL);
   assign ovf_reload  = t2_rollover & (reload_q == RELOAD_OVERFLOW);

   // A software write wins over the timer's own update in the same clock.
   always_comb
   begin
      if (t2_write_i)
      begin
         t2_d = t2_write_data_i;
      end
      else if (ext_reload || ovf_reload)
      begin
         t2_d = t2_reload_value_i;
      end
      else if (t2_inc)
      begin
         t2_d = t2_next[WIDTH-1:0];
      end
      else
      begin
         t2_d = t2_q;
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         t2_q       <= `TIMER_RESET_VALUE;
         ovf_flag_q <= 1'b0;
         ext_flag_q <= 1'b0;
      end
      else
      begin
         t2_q       <= t2_d;
         // A set in the same clock as a clear wins, so no event goes unseen.
         ovf_flag_q <= t2_rollover | (ovf_flag_q & ~t2_overflow_clear_i);
         ext_flag_q <= (trig_fall & ext_en_q) | (ext_flag_q & ~t2_external_clear_i);
      end
   end

   // -------------------------------------------------------------------------
   // Timer 2 outputs
   // -------------------------------------------------------------------------
   assign timer2_count_o     = t2_q;
   assign t2_mode_o          = mode_q;
   assign t2_overflow_flag_o = ovf_flag_q;
   assign t2_external_flag_o = ext_flag_q;

endmodule

//--- testbench/timer_counter_asserts.sv
// Port checker for the timer/counter unit, bound to its top module.
`timescale 1ns/100ps
module timer_counter_asserts
   import timer_counter_pkg::*;
#(
   parameter int WIDTH = 16
)
(
   input wire logic             mclk_i,
   input wire logic             reset_i,
   input wire logic             t01_write_i,
   input wire logic             control_write_i,
   input wire logic [1:0]       t2_mode_i,
   input wire logic             t2_write_i,
   input wire logic [WIDTH-1:0] t2_write_data_i,
   input wire logic [WIDTH-1:0] t2_reload_value_i,
   input wire logic             t2_overflow_clear_i,
   input wire logic             t2_external_clear_i,
   input wire logic [WIDTH-1:0] t0_count_o,
   input wire logic             t0_overflow_o,
   input wire logic [WIDTH-1:0] timer2_count_o,
   input wire logic [1:0]       t2_mode_o,
   input wire logic             t2_overflow_flag_o,
   input wire logic             t2_external_flag_o
);
   // -------------------------------------------------------------------------
   // Relations between the unit's ports
   // -------------------------------------------------------------------------
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);

   AST_MODE_LATCH: assert property (control_write_i |=> t2_mode_o == $past(t2_mode_i))
      else $error("timer 2 mode not latched");
   AST_T2_STOPPED: assert property (
      t2_mode_o == T2_STOPPED && !control_write_i && !t2_write_i |=>
      $stable(timer2_count_o) || timer2_count_o == $past(t2_reload_value_i))
      else $error("timer 2 moved while stopped");
   AST_T2_WRITE: assert property (t2_write_i |=> timer2_count_o == $past(t2_write_data_i))
      else $error("timer 2 write lost");
   AST_OVF_SET: assert property (
      $past(timer2_count_o) == '1 && timer2_count_o == '0 && !$past(t2_write_i) |->
      t2_overflow_flag_o) else $error("roll-over did not set the flag");
   AST_OVF_HOLD: assert property (
      t2_overflow_flag_o && !t2_overflow_clear_i |=> t2_overflow_flag_o)
      else $error("overflow flag dropped");
   AST_EXT_HOLD: assert property (
      t2_external_flag_o && !t2_external_clear_i |=> t2_external_flag_o)
      else $error("external flag dropped");
   // Ticks come every six clocks, so two steps closer together mean a broken divider.
   AST_T2_RATE: assert property (
      timer2_count_o == WIDTH'($past(timer2_count_o) + 1'b1) && !$past(t2_write_i) |=>
      ($stable(timer2_count_o) || $past(t2_write_i) ||
       timer2_count_o == $past(t2_reload_value_i)) [*5])
      else $error("timer 2 counts too fast");
   AST_T0_RATE: assert property (
      t0_count_o == WIDTH'($past(t0_count_o) + 1'b1) && !$past(t01_write_i) |=>
      ($stable(t0_count_o) || $past(t01_write_i)) [*5]) else $error("timer 0 too fast");
   AST_T0_WRAP: assert property (
      t0_overflow_o |-> t0_count_o == '0 && $past(t0_count_o) == '1)
      else $error("timer 0 overflow without wrap");
endmodule

bind timer_counter_unit timer_counter_asserts #(.WIDTH(WIDTH)) checker_inst
(
   .mclk_i, .reset_i, .t01_write_i, .control_write_i, .t2_mode_i, .t2_write_i,
   .t2_write_data_i, .t2_reload_value_i, .t2_overflow_clear_i, .t2_external_clear_i,
   .t0_count_o, .t0_overflow_o, .timer2_count_o, .t2_mode_o, .t2_overflow_flag_o,
   .t2_external_flag_o
);

//--- testbench/ext_pin_model.sv
// Behavioural model of the outside pins that feed the timer/counter unit.
`timescale 1ns/100ps
module ext_pin_model
(
   input  wire logic mclk_i,
   output logic      timer0_count_pin_o,
   output logic      timer1_count_pin_o,
   output logic      ext_irq0_gate_pin_n_o,
   output logic      ext_irq1_gate_pin_n_o,
   output logic      timer2_gate_count_pin_o,
   output logic      timer2_reload_trigger_pin_o
);
   // -------------------------------------------------------------------------
   // Pin levels
   // -------------------------------------------------------------------------
   // The pins have pull-ups, so a pin that is not pulled low rests high.
   logic [5:0] level = 6'h3f;

   assign {timer2_reload_trigger_pin_o, timer2_gate_count_pin_o, ext_irq1_gate_pin_n_o,
           ext_irq0_gate_pin_n_o, timer1_count_pin_o, timer0_count_pin_o} = level;

   task automatic set(input int pin, input logic lvl);
      level[pin] = lvl;
   endtask

   // A hold below six clocks could slip between two samples and be lost.
   task automatic pulses(input int pin, input int n, input int hold);
      repeat (n)
      begin
         level[pin] = 1'b0;
         repeat (hold) @(negedge mclk_i);
         level[pin] = 1'b1;
         repeat (hold) @(negedge mclk_i);
      end
   endtask
endmodule

//--- testbench/testbench.sv
// Self-checking testbench for the timer/counter unit.
`timescale 1ns/100ps
module testbench
   import timer_counter_pkg::*;
;
   logic        mclk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        t0_run_i, t0_counter_sel_i, t1_run_i, t1_gate_en_i, t01_write_i;
   logic        t0_gate_en_i, t1_counter_sel_i, t01_write_sel_i, t1_overflow_o;
   logic [15:0] t1_ovf_count = 16'h0000;
   logic        control_write_i, t2_prescale_div12_i, t2_external_trigger_enable_i;
   logic        t2_write_i, t2_overflow_clear_i, t2_external_clear_i;
   logic        t2_overflow_flag_o, t2_external_flag_o;
   logic        timer0_count_pin_i, timer1_count_pin_i, ext_irq0_gate_pin_n_i;
   logic        ext_irq1_gate_pin_n_i, timer2_gate_count_pin_i, timer2_reload_trigger_pin_i;
   logic [1:0]  t2_mode_i, t2_reload_mode_i, t2_mode_o;
   logic [15:0] t01_write_data_i, t2_reload_value_i, t2_write_data_i, v0, v1, v2;
   logic [15:0] t0_count_o, t1_count_o, timer2_count_o;
   int          errors = 0;
   int          num_checks = 0;

   always #20 mclk_i = ~mclk_i;

   timer_counter_unit dut
   (
      .mclk_i, .reset_i, .timer0_count_pin_i, .timer1_count_pin_i,
      .ext_irq0_gate_pin_n_i, .ext_irq1_gate_pin_n_i, .timer2_gate_count_pin_i,
      .timer2_reload_trigger_pin_i, .t0_run_i, .t0_counter_sel_i, .t0_gate_en_i,
      .t1_run_i, .t1_counter_sel_i, .t1_gate_en_i, .t01_write_i, .t01_write_sel_i,
      .t01_write_data_i, .t2_mode_i, .t2_prescale_div12_i, .t2_reload_mode_i,
      .t2_external_trigger_enable_i, .control_write_i, .t2_reload_value_i, .t2_write_i,
      .t2_write_data_i, .t2_overflow_clear_i, .t2_external_clear_i, .t0_count_o, .t1_count_o,
      .t0_overflow_o(), .t1_overflow_o, .timer2_count_o, .t2_mode_o, .t2_overflow_flag_o,
      .t2_external_flag_o
   );

   ext_pin_model pins
   (
      .mclk_i, .timer0_count_pin_o(timer0_count_pin_i), .timer1_count_pin_o(timer1_count_pin_i),
      .ext_irq0_gate_pin_n_o(ext_irq0_gate_pin_n_i), .ext_irq1_gate_pin_n_o(ext_irq1_gate_pin_n_i),
      .timer2_gate_count_pin_o(timer2_gate_count_pin_i),
      .timer2_reload_trigger_pin_o(timer2_reload_trigger_pin_i)
   );

   // -------------------------------------------------------------------------
   // Access tasks
   // -------------------------------------------------------------------------
   task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", n, exp, got);
      end
   endtask

   // Overflow pulses last a whole clock, so the falling edge always catches them.
   always @(negedge mclk_i)
      t1_ovf_count <= t1_ovf_count + {15'h0000, t1_overflow_o};

   task automatic cyc(input int n);
      repeat (n) @(negedge mclk_i);
   endtask

   // Counts are read as differences, so a window of whole machine cycles is exact.
   task automatic win(input int n);
      {v0, v1, v2} = {t0_count_o, t1_count_o, timer2_count_o};
      cyc(n);
   endtask

   task automatic ctl(input t2_mode_t m, input logic d, input reload_mode_t r, input logic e);
      {t2_mode_i, t2_prescale_div12_i, t2_reload_mode_i} = {m, d, r};
      {t2_external_trigger_enable_i, control_write_i} = {e, 1'b1};
      cyc(1);
      control_write_i = 1'b0;
      cyc(1);
   endtask

   task automatic wr(input logic t2, input logic [15:0] d);
      {t2_write_data_i, t01_write_data_i, t2_write_i, t01_write_i} = {d, d, t2, !t2};
      cyc(1);
      {t2_write_i, t01_write_i} = 2'h0;
      cyc(1);
   endtask

   task automatic clr(input logic e);
      {t2_external_clear_i, t2_overflow_clear_i} = {e, !e};
      cyc(1);
      {t2_external_clear_i, t2_overflow_clear_i} = 2'h0;
      cyc(1);
   endtask

   task automatic stop_test;
      $display("checks %0d, errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // -------------------------------------------------------------------------
   // Test sequence
   // -------------------------------------------------------------------------
   initial
   begin
      {t0_run_i, t0_counter_sel_i, t1_run_i, t1_gate_en_i, t01_write_i, control_write_i} = '0;
      {t2_prescale_div12_i, t2_external_trigger_enable_i, t2_write_i, t2_mode_i} = '0;
      {t2_overflow_clear_i, t2_external_clear_i, t2_reload_mode_i, t01_write_data_i} = '0;
      {t2_reload_value_i, t2_write_data_i} = '0;
      {t0_gate_en_i, t1_counter_sel_i, t01_write_sel_i} = '0;
      cyc(16);
      reset_i = 1'b0;
      cyc(1);
      chk("mode", t2_mode_o, T2_STOPPED);
      chk("flags", {t2_overflow_flag_o, t2_external_flag_o}, 2'h0);
      {t0_run_i, t1_run_i, t1_gate_en_i} = 3'h7;
      pins.set(3, 1'b0);
      wr(0, 16'hfffc);
      cyc(6);
      win(60);
      chk("t0 timer", t0_count_o - v0, 16'h000a);
      chk("t1 gate shut", t1_count_o - v1, 16'h0000);
      pins.set(3, 1'b1);
      cyc(12);
      win(60);
      chk("t1 gate open", t1_count_o - v1, 16'h000a);
      t0_counter_sel_i = 1'b1;
      win(12);
      pins.pulses(0, 5, 12);
      cyc(12);
      chk("t0 counter", t0_count_o - v0, 16'h0005);
      t0_gate_en_i = 1'b1;
      pins.set(2, 1'b0);
      cyc(12);
      win(12);
      pins.pulses(0, 2, 12);
      cyc(12);
      chk("t0 gate shut", t0_count_o - v0, 16'h0000);
      t1_counter_sel_i = 1'b1;
      t01_write_sel_i  = 1'b1;
      wr(0, 16'hfffe);
      chk("t1 write", t1_count_o, 16'hfffe);
      pins.pulses(1, 2, 12);
      cyc(12);
      chk("t1 counter", t1_count_o, 16'h0000);
      chk("t1 overflow", t1_ovf_count, 16'h0001);
      ctl(T2_TIMER, 1'b0, RELOAD_OFF, 1'b0);
      win(60);
      chk("t2 div6", timer2_count_o - v2, 16'h000a);
      ctl(T2_TIMER, 1'b1, RELOAD_OFF, 1'b0);
      win(60);
      chk("t2 div12", timer2_count_o - v2, 16'h0005);
      ctl(T2_TIMER, 1'b0, RELOAD_OFF, 1'b0);
      wr(1, 16'hffff);
      cyc(5);
      chk("t2 wrap", timer2_count_o, 16'h0000);
      chk("ovf set", t2_overflow_flag_o, 1'h1);
      cyc(12);
      chk("ovf held", t2_overflow_flag_o, 1'h1);
      clr(0);
      chk("ovf clear", t2_overflow_flag_o, 1'h0);
      t2_reload_value_i = 16'h1234;
      ctl(T2_TIMER, 1'b0, RELOAD_OVERFLOW, 1'b0);
      wr(1, 16'hfffe);
      cyc(11);
      chk("reload ovf", timer2_count_o, 16'h1234);
      chk("ovf reload", t2_overflow_flag_o, 1'h1);
      ctl(T2_GATED, 1'b0, RELOAD_OFF, 1'b0);
      pins.set(4, 1'b0);
      cyc(12);
      win(60);
      chk("t2 gate shut", timer2_count_o - v2, 16'h0000);
      pins.set(4, 1'b1);
      cyc(12);
      win(60);
      chk("t2 gate open", timer2_count_o - v2, 16'h000a);
      ctl(T2_EVENT, 1'b0, RELOAD_OFF, 1'b0);
      win(12);
      pins.pulses(4, 4, 6);
      cyc(12);
      chk("t2 events", timer2_count_o - v2, 16'h0004);
      t2_reload_value_i = 16'habcd;
      ctl(T2_STOPPED, 1'b0, RELOAD_EXTERNAL, 1'b0);
      pins.pulses(5, 1, 12);
      chk("trigger load", timer2_count_o, 16'habcd);
      chk("ext flag off", t2_external_flag_o, 1'h0);
      ctl(T2_STOPPED, 1'b0, RELOAD_EXTERNAL, 1'b1);
      wr(1, 16'h0000);
      pins.pulses(5, 1, 12);
      chk("ext flag on", t2_external_flag_o, 1'h1);
      clr(1);
      chk("ext clear", t2_external_flag_o, 1'h0);
      stop_test;
   end

   // The sequence needs about 890 clocks; this leaves ample margin.
   initial
   begin
      repeat (4000) @(posedge mclk_i);
      errors++;
      stop_test;
   end
endmodule
